// ===== core/phase_counter.sv
// Four-phase instruction cycle sequencer.
`timescale 1ns/1ps
module phase_counter
  import stack_ops_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  output logic [1:0] phase_o
);
  logic [1:0] phase;
  logic [1:0] next_phase;

  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      phase <= PHASE_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  assign phase_o = phase;
endmodule

// ===== core/return_stack_call_reset_ops.sv
// Decoder and executor for push, relative subroutine call and software master clear.
`timescale 1ns/1ps
module return_stack_call_reset_ops
  import stack_ops_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] status_i,
  input wire logic status_we_i,
  output logic [PC_W-1:0] fetch_addr_o,
  output logic [1:0] phase_o,
  output logic sw_reset_o,
  output logic call_busy_o,
  output core_view_t view_o
);
  typedef struct packed {
    exec_state_t st;
    logic [PC_W-1:0] pc;
    logic [PTR_W-1:0] ptr;
    logic [15:0] ir;
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] target;
    logic [7:0] status;
    logic sw_reset;
  } state_t;

  // One instruction cycle is four clock edges, counted by the phase sequencer.
  // Phase Q1 drops the software reset request left from the previous cycle.
  // Phase Q2 carries out the word latched at the end of the previous cycle.
  // Phase Q3 has no decode action of its own; a pending software reset lands here.
  // Phase Q4 latches the next word and steps the program counter by one word.
  // The program counter always holds the address after the word being executed.
  // That is why a push stores the counter as it stands, with no extra addition.
  // A relative call reads that same counter as its base, so its target already
  // includes the step over the call word itself.
  // The offset counts words, and one word is two address units.
  // Doubling the offset keeps every call target on a word boundary.
  // The call target is worked out in Q2 and held until Q4 writes it to the counter.
  // The return address is stored in Q2, before the counter changes in Q4.
  // The word fetched in the Q4 of a call belongs to the old path and is dropped.
  // The following cycle is a no-operation cycle while the target word is fetched.
  // No decode happens during that cycle, so the cleared latched word does nothing; its Q4 latches the target word.
  // The stack pointer counts every push, also those that no longer fit.
  // Pushes past the last slot are not stored and the pointer wraps around.
  // The newest return address is also kept in the state, though the top readout never selects it.
  // A software reset is requested in Q2 and applied one edge later.
  // Applying it clears the counter, the pointer, the latched word and the status.
  // A status write in the same cycle as the applied reset is lost: reset wins.
  // The phase sequencer is not cleared by a software reset.
  // The reset lands with the sequencer in Q3, so the next edge is a Q4 fetch.
  // That fetch reads address zero, exactly as after a power-up reset.
  // The software reset output therefore stands for a single clock cycle.
  // The external reset input clears every field at once on the clock edge.
  // Status flags are only written through the status write strobe, and cleared by either reset.
  // Neither a push nor a call ever touches the status flags.
  // The stack array is written on the Q2 edge, together with the new pointer.

  state_t r;
  state_t next_r;
  logic [1:0] phase;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic push_en;
  logic [PTR_W-1:0] push_slot;
  logic is_push;
  logic is_relative_subroutine_call;
  logic is_reset;
  logic [PC_W-1:0] offset_ext;
  logic [PC_W-1:0] top_value;
  logic [PTR_W-1:0] top_slot;
  logic [PC_W-1:0] ret_calc;
  logic [PC_W-1:0] target_calc;
  core_view_t view;

  phase_counter u_phase (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .phase_o(phase)
  );

  always_comb begin
    is_push = (r.st == ST_FETCH) && (r.ir == OPC_PUSH);
    is_relative_subroutine_call = (r.st == ST_FETCH) && (r.ir[15:11] == OPC_RELATIVE_SUBROUTINE_CALL_PREFIX);
    is_reset = (r.st == ST_FETCH) && (r.ir == OPC_RESET);
    offset_ext = PC_W'({{(PC_W-OFFSET_W){r.ir[OFFSET_W-1]}}, r.ir[OFFSET_W-1:0]});
  end

  // The return address and the call target both start from the incremented counter.
  // The sum wraps at the counter width, so a backward call near zero wraps high.
  always_comb begin
    ret_calc = r.pc;
    target_calc = PC_W'(r.pc + PC_W'(offset_ext << 1));
  end

  // Next-state logic for the whole core state.
  // Every field keeps its value unless the current phase has work for it.
  // The status write strobe is honoured in every phase.
  // The software reset branch at the end overrides all earlier assignments.
  // Only the latched word decides the action; the incoming word is read in Q4 only.
  // A call keeps its latched word until Q4, so Q4 still sees the call decoded.

  always_comb begin
    next_r = r;
    push_en = 1'b0;
    push_slot = r.ptr;
    if (status_we_i) begin
      next_r.status = status_i;
    end
    case (phase)
      PHASE_Q1: begin
        next_r.sw_reset = 1'b0;
      end
      PHASE_Q2: begin
        if (is_push || is_relative_subroutine_call) begin
          // Pushed value is the already incremented PC, written before any PC change.
          push_en = 1'b1;
          push_slot = r.ptr;
          next_r.ptr = PTR_W'(r.ptr + 5'h01);
          next_r.ret_addr = ret_calc;
        end
        if (is_relative_subroutine_call) begin
          next_r.target = target_calc;
        end
        if (is_reset) begin
          next_r.sw_reset = 1'b1;
        end
      end
      PHASE_Q4: begin
        next_r.ir = instr_i;
        next_r.pc = PC_W'(r.pc + PC_STEP);
        next_r.st = ST_FETCH;
        if (is_relative_subroutine_call) begin
          // Target fetch waits one cycle; the word already fetched is discarded.
          next_r.pc = r.target;
          next_r.st = ST_CALL_NOP;
          next_r.ir = 16'h0000;
        end
      end
      default: begin
        next_r.sw_reset = r.sw_reset;
      end
    endcase
    if (r.sw_reset) begin
      next_r.st = ST_FETCH;
      next_r.pc = PC_RESET;
      next_r.ptr = PTR_RESET;
      next_r.ir = 16'h0000;
      next_r.status = STATUS_RESET;
      next_r.ret_addr = PC_RESET;
      next_r.target = PC_RESET;
      next_r.sw_reset = 1'b0;
    end
  end

  // The external reset is synchronous and clears every state field.
  // The stack array itself is not cleared; the zero pointer hides its contents.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      r.st <= ST_FETCH;
      r.pc <= PC_RESET;
      r.ptr <= PTR_RESET;
      r.ir <= 16'h0000;
      r.ret_addr <= PC_RESET;
      r.target <= PC_RESET;
      r.status <= STATUS_RESET;
      r.sw_reset <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Stack storage; a push beyond the last slot is dropped here.
  always_ff @(posedge core_clk_i) begin
    if (push_en && (push_slot < PTR_W'(STACK_DEPTH))) begin
      stack_mem[push_slot] <= r.pc;
    end
  end

  // The top is read back from the stack; once the pointer wraps to zero the top reads as PC_RESET.
  always_comb begin
    top_slot = PTR_W'(r.ptr - PTR_W'(1));
    top_value = PC_RESET;
    if (r.ptr != PTR_RESET) begin
      top_value = r.ret_addr;
      if (top_slot < PTR_W'(STACK_DEPTH)) begin
        top_value = stack_mem[top_slot];
      end
    end
  end

  always_comb begin
    view = '{pc: r.pc, top_of_return_stack: top_value, stack_ptr: r.ptr, status: r.status};
  end

  assign fetch_addr_o = r.pc;
  assign phase_o = phase;
  assign sw_reset_o = r.sw_reset;
  assign call_busy_o = (r.st == ST_CALL_NOP);
  assign view_o = view;
endmodule

// ===== core/stack_ops_pkg.sv
// Constants, encodings and carrier types for the return stack, call and reset instruction decoder.
package stack_ops_pkg;
  localparam int PC_W = 21;
  localparam int STACK_DEPTH = 31;
  localparam int PTR_W = 5;
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_RESET = 16'h00FF;
  localparam logic [4:0] OPC_RELATIVE_SUBROUTINE_CALL_PREFIX = 5'h1B;
  localparam int OFFSET_W = 11;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
  localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_CALL_NOP = 2'b01
  } exec_state_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] top_of_return_stack;
    logic [PTR_W-1:0] stack_ptr;
    logic [7:0] status;
  } core_view_t;
endpackage

// ===== tb/pmem.sv
// Program memory model holding the test program.
`timescale 1ns/1ps
module pmem import stack_ops_pkg::*; (
  input logic [PC_W-1:0] addr_i,
  output logic [15:0] word_o
);
  assign word_o = addr_i == 21'h00_0000 ? OPC_PUSH : addr_i == 21'h00_0002 ? 16'hD803 :
    addr_i == 21'h00_000A ? 16'hDC00 : addr_i == 21'h1F_F80C ? OPC_RESET : 16'h0000;
endmodule

// ===== tb/sop_props.sv
// Push, call and reset checker.
`timescale 1ns/1ps
module sop_props import stack_ops_pkg::*; (
  input logic core_clk_i,
  input logic reset_i,
  input logic [15:0] instr_i,
  input logic status_we_i,
  input logic [PC_W-1:0] fetch_addr_o,
  input logic [1:0] phase_o,
  input logic sw_reset_o,
  input logic call_busy_o,
  input core_view_t view_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [PC_W-1:0] dst;
  wire go = phase_o == PHASE_Q4 && !call_busy_o;
  wire push = go && instr_i == OPC_PUSH;
  wire call = go && instr_i[15:11] == OPC_RELATIVE_SUBROUTINE_CALL_PREFIX;
  wire [PC_W-1:0] top = view_o.top_of_return_stack;
  wire [PTR_W-1:0] ptr = view_o.stack_ptr;
  always_ff @(posedge core_clk_i) if (call) dst <= fetch_addr_o + PC_STEP + {{9{instr_i[10]}}, instr_i[10:0], 1'b0};
  a_push_top: assert property (push || call |-> ##[1:4] top == fetch_addr_o) else $error("top");
  a_stack_ptr: assert property (push || call |-> ##[1:4] ptr == $past(ptr) + 1'b1) else $error("ptr");
  a_call_dest: assert property (call |-> ##[2:6] fetch_addr_o == dst) else $error("dest");
  a_call_len: assert property (call |-> ##[1:6] $rose(call_busy_o) ##0 call_busy_o [*4] ##1 !call_busy_o)
    else $error("nop");
  a_push_once: assert property (push |=> !call_busy_o [*4]) else $error("push");
  a_flags_kept: assert property (!status_we_i && !sw_reset_o |=> $stable(view_o.status)) else $error("flag");
  a_reset_start: assert property ($rose(sw_reset_o) |-> phase_o == 2'h2 ##[1:2] !sw_reset_o) else $error("rst");
  a_reset_clear: assert property ($fell(sw_reset_o) |-> view_o == '0) else $error("clr");
  cover property (push);
  cover property (call);
  cover property ($fell(sw_reset_o));
endmodule
bind return_stack_call_reset_ops sop_props u_sop_props (.core_clk_i, .reset_i, .instr_i, .status_we_i,
  .fetch_addr_o, .phase_o, .sw_reset_o, .call_busy_o, .view_o);

// ===== tb/tb_return_stack_call_reset_ops.sv
// Bench for the return stack, call and reset decoder.
`timescale 1ns/1ps
module tb_return_stack_call_reset_ops import stack_ops_pkg::*; ;
  logic core_clk_i = 0, reset_i = 1, status_we_i = 0;
  logic [15:0] instr_i;
  logic [PC_W-1:0] fetch_addr_o;
  logic [1:0] phase_o;
  logic sw_reset_o;
  core_view_t view_o;
  int err_total = 0, check_count = 0;
  core_view_t rows [3] = '{{21'h00_0002, 21'h00_0002, 5'h01, 8'h5A}, {21'h00_000A, 21'h00_0004, 5'h02, 8'h5A},
    {21'h1F_F80C, 21'h00_000C, 5'h03, 8'h5A}};
  pmem u_pmem (.addr_i(fetch_addr_o), .word_o(instr_i));
  return_stack_call_reset_ops u_return_stack_call_reset_ops (.core_clk_i, .reset_i, .instr_i, .status_i(8'h5A),
    .status_we_i, .fetch_addr_o, .phase_o, .sw_reset_o, .call_busy_o(), .view_o);
  always #2.5 core_clk_i = ~core_clk_i;
  task automatic wrap_up;
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic till(input core_view_t v);
    for (int k = 0; k < 80 && view_o !== v; k++) @(negedge core_clk_i);
    chk("view", view_o, v);
    if (err_total > 0) wrap_up();
  endtask
  initial begin
    repeat (5) @(negedge core_clk_i);
    reset_i = 0;
    status_we_i = 1;
    @(negedge core_clk_i);
    status_we_i = 0;
    foreach (rows[i]) till(rows[i]);
    for (int k = 0; k < 80 && sw_reset_o !== 1'b1; k++) @(negedge core_clk_i);
    chk("sw_reset", sw_reset_o, 1'b1);
    chk("phase", phase_o, 2'h2);
    till('0);
    wrap_up();
  end
endmodule
